// >>> verilog/sac_top.sv
// converter serial control: frame logic on the serial clock, conversion control on the system clock
`timescale 1ns/1ps

// Contract
// - internal clock times conversion, 365 ns max
// - chip-select-only mode and frame-sync mode
// - busy output high during conversion
// - result sent as straight binary code
// - result word 14 bits, 16384 steps
// - powerdown/reset pin active low, asynchronous
// - reset abandons conversion within 45 ns
// - serial output high impedance during reset
// - short reset release resumes operation at once
// - first four conversions after reset invalid
// - long reset low enters powerdown
// - normal again within wake delay after powerdown
// - nap entered when busy falls
// - nap left on 8th rising edge
// - msb first, bits shift to 14th edge
// - sample on 9th edge, convert at 16th
// - frame-sync rise starts frame, chip select low
// - aborted conversion shows 3f80 next frame
module sac_top
   import sac_pkg::*;
(
   // system clock and reset
   input  wire logic                clk_i,
   input  wire logic                reset_n_i,
   // host serial link
   input  wire logic                sclk_i,
   input  wire logic                cs_n_i,
   input  wire logic                frame_sync_strobe_i,
   output logic                     serial_result_out_o,
   output logic                     serial_result_out_oe_o,
   // configuration and power pins
   input  wire logic                mode_frame_sync_i,
   input  wire logic                powerdown_reset_n_i,
   // converter core
   input  wire logic [RESULT_W-1:0] sar_code_i,
   output logic                     sample_switch_o,
   // status
   output logic                     busy_o,
   output logic                     nap_o,
   output logic                     powerdown_o,
   output logic                     result_invalid_o
);

   // ***************************************************************
   // resets
   // ***************************************************************
   logic rst_n;        // system reset, released through two flops
   logic conv_rst_n;   // system or pin reset, asserts at once
   logic link_rst_n;   // reset for the link toggles
   logic frame_rst_n;  // ends a frame: chip select high or pin reset
   logic pin_n_s;      // pin level seen in the system domain

   sac_sync u_rst_sync (
      .clk_i   (clk_i),
      .rst_n_i (reset_n_i),
      .d_i     (1'b1),
      .q_o     (rst_n)
   );

   // pin reset asserts asynchronously and kills conversion in the same instant
   sac_sync u_conv_rst_sync (
      .clk_i   (clk_i),
      .rst_n_i (reset_n_i & powerdown_reset_n_i),
      .d_i     (1'b1),
      .q_o     (conv_rst_n)
   );

   sac_sync u_pin_sync (
      .clk_i   (clk_i),
      .rst_n_i (rst_n),
      .d_i     (powerdown_reset_n_i),
      .q_o     (pin_n_s)
   );

   // the serial clock may stand still, so its resets cannot wait for its edges
   assign link_rst_n  = reset_n_i & powerdown_reset_n_i;
   assign frame_rst_n = link_rst_n & ~cs_n_i;

   // ***************************************************************
   // link domain: frame tracking on serial clock rising edges
   // ***************************************************************
   logic                in_frame_ff;   // a frame is open
   logic [4:0]          edge_cnt_ff;   // rising edges counted in this frame
   logic [RESULT_W-1:0] shift_ff;      // remaining result bits
   logic                sdo_ff;        // serial data bit
   logic                sdo_oe_ff;     // serial data driven
   logic                fs_prev_ff;    // strobe on the previous edge
   logic                sample_ff;     // sampling switch closed
   logic                frame_tgl_ff;  // flips on each frame start
   logic                wake_tgl_ff;   // flips on the nap exit edge
   logic                conv_tgl_ff;   // flips on the convert edge
   logic                busy_link;     // busy seen on the serial clock
   logic                frame_start;   // this edge opens a frame
   logic [4:0]          nxt_edge_cnt;  // edge count after this edge
   logic [RESULT_W-1:0] load_word;     // word for a new frame
   logic                busy_ff;       // timer busy flag, system domain
   logic [RESULT_W-1:0] result_ff;     // last finished result, steady while a frame runs

   // strobe is driven by the host on the serial clock, so no synchroniser
   always_ff @(posedge sclk_i or negedge link_rst_n) begin
      if (!link_rst_n) begin
         fs_prev_ff <= 1'b0;
      end else begin
         fs_prev_ff <= frame_sync_strobe_i;
      end
   end

   // frame start rule differs per mode; a strobe rise mid-frame restarts it
   always_comb begin
      if (mode_frame_sync_i) begin
         frame_start = frame_sync_strobe_i & ~fs_prev_ff;
      end else begin
         frame_start = ~in_frame_ff;
      end
      nxt_edge_cnt = frame_start ? EDGE_FIRST : edge_cnt_ff + EDGE_ONE;
      // a frame that opens during a conversion aborts it and shows the fixed code
      load_word    = busy_link ? CODE_ABORT : result_ff;
   end

   // edge counter and serial shifter; chip select high clears them at once
   always_ff @(posedge sclk_i or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         in_frame_ff <= 1'b0;
         edge_cnt_ff <= '0;
         shift_ff    <= '0;
         sdo_ff      <= 1'b0;
         sdo_oe_ff   <= 1'b0;
         sample_ff   <= 1'b0;
      end else if (frame_start) begin
         in_frame_ff <= 1'b1;
         edge_cnt_ff <= EDGE_FIRST;
         sdo_ff      <= load_word[MSB_IDX];
         shift_ff    <= {load_word[RESULT_W-2:0], 1'b0};
         sdo_oe_ff   <= 1'b1;
         sample_ff   <= 1'b0;
      end else if (in_frame_ff) begin
         // hold the count once the conversion edge has passed
         if (edge_cnt_ff < EDGE_CONVERT) begin
            edge_cnt_ff <= nxt_edge_cnt;
         end
         // one bit per edge up to the last one
         if (edge_cnt_ff < EDGE_LAST_BIT) begin
            sdo_ff   <= shift_ff[MSB_IDX];
            shift_ff <= {shift_ff[RESULT_W-2:0], 1'b0};
         end
         // switch closes on the sample edge and opens on the convert edge
         if (nxt_edge_cnt == EDGE_SAMPLE) begin
            sample_ff <= 1'b1;
         end else if (nxt_edge_cnt == EDGE_CONVERT) begin
            sample_ff <= 1'b0;
         end
      end
   end

   // event toggles survive chip select, so an event is never half sent
   always_ff @(posedge sclk_i or negedge link_rst_n) begin
      if (!link_rst_n) begin
         frame_tgl_ff <= 1'b0;
         wake_tgl_ff  <= 1'b0;
         conv_tgl_ff  <= 1'b0;
      end else if (!cs_n_i) begin
         if (frame_start) begin
            frame_tgl_ff <= ~frame_tgl_ff;
         end
         if (in_frame_ff && !frame_start && edge_cnt_ff < EDGE_CONVERT) begin
            if (nxt_edge_cnt == EDGE_NAP_EXIT) begin
               wake_tgl_ff <= ~wake_tgl_ff;
            end
            if (nxt_edge_cnt == EDGE_CONVERT) begin
               conv_tgl_ff <= ~conv_tgl_ff;
            end
         end
      end
   end

   sac_sync u_busy_link_sync (
      .clk_i   (sclk_i),
      .rst_n_i (link_rst_n),
      .d_i     (busy_ff),
      .q_o     (busy_link)
   );

   assign serial_result_out_o    = sdo_ff;
   assign serial_result_out_oe_o = sdo_oe_ff;
   assign sample_switch_o        = sample_ff;

   // ***************************************************************
   // crossing of link events into the system domain
   // ***************************************************************
   logic [2:0] tgl_s;        // synchronised toggles: frame, wake, convert
   logic [2:0] tgl_prev_ff;  // toggles one cycle earlier
   logic [2:0] tgl_src;      // toggles at the link side
   logic       frame_evt;    // a frame opened
   logic       wake_evt;     // nap exit edge seen
   logic       conv_evt;     // convert edge seen

   assign tgl_src = {conv_tgl_ff, wake_tgl_ff, frame_tgl_ff};

   for (genvar g = 0; g < 3; g++) begin : g_evt_sync
      sac_sync u_evt_sync (
         .clk_i   (clk_i),
         .rst_n_i (conv_rst_n),
         .d_i     (tgl_src[g]),
         .q_o     (tgl_s[g])
      );
   end

   // edge detect on the second stage only
   always_ff @(posedge clk_i or negedge conv_rst_n) begin
      if (!conv_rst_n) begin
         tgl_prev_ff <= '0;
      end else begin
         tgl_prev_ff <= tgl_s;
      end
   end

   assign frame_evt = tgl_s[0] ^ tgl_prev_ff[0];
   assign wake_evt  = tgl_s[1] ^ tgl_prev_ff[1];
   assign conv_evt  = tgl_s[2] ^ tgl_prev_ff[2];

   // ***************************************************************
   // system domain: power and conversion control
   // ***************************************************************
   sac_state_t        state_ff;     // control state
   sac_state_t        nxt_state;    // next control state
   logic [TCNT_W-1:0] hold_cnt_ff;  // cycles with the pin low
   logic [TCNT_W-1:0] wake_cnt_ff;  // cycles since wake started
   logic              conv_start;   // launch the timer
   logic              conv_abort;   // drop the running conversion
   logic              conv_done;    // timer finished
   logic [2:0]        init_cnt_ff;  // conversions since reset
   logic              invalid_ff;   // result still from start-up
   logic              nap_ff;       // nap flag
   logic              pd_ff;        // powerdown flag

   assign conv_start = conv_evt && (state_ff == ST_AWAKE || state_ff == ST_NAP);
   assign conv_abort = frame_evt && (state_ff == ST_CONVERT);

   sac_conv_timer u_timer (
      .clk_i   (clk_i),
      .rst_n_i (conv_rst_n),
      .start_i (conv_start),
      .abort_i (conv_abort),
      .busy_o  (busy_ff),
      .done_o  (conv_done)
   );

   // count how long the pin has been low
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         hold_cnt_ff <= '0;
      end else if (pin_n_s) begin
         hold_cnt_ff <= '0;
      end else if (hold_cnt_ff < HOLD_LIMIT) begin
         hold_cnt_ff <= hold_cnt_ff + 8'h01;
      end
   end

   // wake delay counter, runs only in the wake state
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         wake_cnt_ff <= '0;
      end else if (state_ff == ST_WAKE) begin
         wake_cnt_ff <= wake_cnt_ff + 8'h01;
      end else begin
         wake_cnt_ff <= '0;
      end
   end

   // next state
   always_comb begin
      nxt_state = state_ff;
      if (!pin_n_s) begin
         // held past the threshold the reset turns into powerdown
         if (hold_cnt_ff >= HOLD_LIMIT || state_ff == ST_POWERDOWN) begin
            nxt_state = ST_POWERDOWN;
         end else begin
            nxt_state = ST_RESET;
         end
      end else begin
         unique case (state_ff)
            ST_AWAKE: begin
               if (conv_start) begin
                  nxt_state = ST_CONVERT;
               end
            end
            ST_CONVERT: begin
               if (conv_done || conv_abort) begin
                  nxt_state = ST_NAP;
               end
            end
            ST_NAP: begin
               if (conv_start) begin
                  nxt_state = ST_CONVERT;
               end else if (wake_evt) begin
                  nxt_state = ST_AWAKE;
               end
            end
            ST_RESET: begin
               nxt_state = ST_AWAKE;
            end
            ST_POWERDOWN: begin
               nxt_state = ST_WAKE;
            end
            ST_WAKE: begin
               // host waits out the delay before framing again
               if (wake_cnt_ff >= WAKE_LIMIT - 8'h01) begin
                  nxt_state = ST_AWAKE;
               end
            end
         endcase
      end
   end

   // state register and flags derived from the next state
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= ST_AWAKE;
         nap_ff   <= 1'b0;
         pd_ff    <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         nap_ff   <= (nxt_state == ST_NAP);
         pd_ff    <= (nxt_state == ST_POWERDOWN) || (nxt_state == ST_WAKE);
      end
   end

   // result capture and start-up count; the pin reset restarts the count
   always_ff @(posedge clk_i or negedge conv_rst_n) begin
      if (!conv_rst_n) begin
         result_ff   <= CODE_ZERO;
         init_cnt_ff <= '0;
         invalid_ff  <= 1'b1;
      end else if (conv_done) begin
         result_ff <= sar_code_i;
         if (init_cnt_ff < INIT_CONVS) begin
            init_cnt_ff <= init_cnt_ff + INIT_STEP;
         end
         // the word of the fourth conversion is still start-up data
         invalid_ff <= (init_cnt_ff + INIT_STEP) <= INIT_CONVS;
      end
   end

   assign busy_o           = busy_ff;
   assign nap_o            = nap_ff;
   assign powerdown_o      = pd_ff;
   assign result_invalid_o = invalid_ff;

endmodule // sac_top

// >>> verilog/sac_pkg.sv
// constants and types shared by the converter serial control block
package sac_pkg;

   // ***************************************************************
   // result word
   // ***************************************************************
   localparam int          RESULT_W        = 14;        // bits per result word
   localparam int          CODE_STEPS      = 16384;     // one step is the reference over this many
   localparam logic [13:0] CODE_FULL_SCALE = 14'h3fff;  // reference minus one step
   localparam logic [13:0] CODE_MIDSCALE   = 14'h2000;  // half the reference
   localparam logic [13:0] CODE_ZERO       = 14'h0000;  // zero input
   localparam logic [13:0] CODE_ABORT      = 14'h3f80;  // shown in the frame after an aborted conversion
   localparam int          MSB_IDX         = 13;        // index of the first bit shifted out

   // ***************************************************************
   // timing, system clock
   // ***************************************************************
   localparam int CLK_PERIOD_NS        = 100;   // system clock period
   localparam int CONV_TIME_NS         = 365;   // longest conversion time
   localparam int ABORT_TIME_NS        = 45;    // longest time to drop a conversion on reset
   localparam int POWERDOWN_HOLD_NS    = 1000;  // reset low longer than this powers down
   localparam int WAKE_DELAY_NS        = 2000;  // longest time back to normal after powerdown
   // longest times round down, least times round up, never below one cycle
   localparam int CONV_CYCLES_RAW      = CONV_TIME_NS / CLK_PERIOD_NS;
   localparam int CONV_CYCLES          = (CONV_CYCLES_RAW < 1) ? 1 : CONV_CYCLES_RAW;
   localparam int HOLD_CYCLES          = (POWERDOWN_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WAKE_CYCLES_RAW      = WAKE_DELAY_NS / CLK_PERIOD_NS;
   localparam int WAKE_CYCLES          = (WAKE_CYCLES_RAW < 1) ? 1 : WAKE_CYCLES_RAW;
   localparam int TCNT_W               = 8;     // width of the time counters
   localparam logic [7:0] HOLD_LIMIT   = 8'(HOLD_CYCLES);
   localparam logic [7:0] WAKE_LIMIT   = 8'(WAKE_CYCLES);
   localparam logic [7:0] CONV_LIMIT   = 8'(CONV_CYCLES);

   // ***************************************************************
   // frame edge numbers, serial clock rising edges
   // ***************************************************************
   localparam logic [4:0] EDGE_FIRST     = 5'h01;  // frame start edge, msb out
   localparam logic [4:0] EDGE_NAP_EXIT  = 5'h08;  // nap ends here
   localparam logic [4:0] EDGE_SAMPLE    = 5'h09;  // sampling switch closes
   localparam logic [4:0] EDGE_LAST_BIT  = 5'h0e;  // lsb goes out here
   localparam logic [4:0] EDGE_CONVERT   = 5'h10;  // conversion starts here
   localparam logic [4:0] EDGE_ONE       = 5'h01;  // counter step

   // ***************************************************************
   // start-up
   // ***************************************************************
   localparam logic [2:0] INIT_CONVS = 3'h4;  // conversions spent initialising
   localparam logic [2:0] INIT_STEP  = 3'h1;  // counter step

   // control states, system clock domain
   typedef enum logic [2:0] {
      ST_AWAKE,      // powered, waiting for a conversion start
      ST_CONVERT,    // conversion running
      ST_NAP,        // low power after a conversion
      ST_RESET,      // reset pin low, not yet powered down
      ST_POWERDOWN,  // reset pin held low past the threshold
      ST_WAKE        // leaving powerdown, wake delay running
   } sac_state_t;

endpackage : sac_pkg

// >>> verilog/sac_sync.sv
// two-flop synchroniser with asynchronous reset, also used as reset release
`timescale 1ns/1ps
module sac_sync (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   // level in and out
   input  wire logic d_i,
   output logic      q_o
);

   logic meta_ff;  // first stage, read only by the second
   logic q_ff;     // second stage

   // ***************************************************************
   // two stages, reset to zero
   // ***************************************************************
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_ff <= 1'b0;
         q_ff    <= 1'b0;
      end else begin
         meta_ff <= d_i;
         q_ff    <= meta_ff;
      end
   end

   assign q_o = q_ff;

endmodule // sac_sync

// >>> verilog/sac_conv_timer.sv
// conversion timer: busy flag and end-of-conversion pulse
`timescale 1ns/1ps
module sac_conv_timer
   import sac_pkg::*;
(
   // clock and reset (reset also aborts at once)
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   // control
   input  wire logic start_i,
   input  wire logic abort_i,
   // status
   output logic      busy_o,
   output logic      done_o
);

   logic [TCNT_W-1:0] cnt_ff;   // cycles spent converting
   logic              busy_ff;  // conversion running
   logic              done_ff;  // one-cycle end pulse

   // ***************************************************************
   // count the internal conversion clock
   // ***************************************************************
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_ff  <= '0;
         busy_ff <= 1'b0;
         done_ff <= 1'b0;
      end else begin
         done_ff <= 1'b0;
         if (abort_i) begin
            // aborted work leaves no result
            busy_ff <= 1'b0;
            cnt_ff  <= '0;
         end else if (start_i && !busy_ff) begin
            busy_ff <= 1'b1;
            cnt_ff  <= 8'h01;
         end else if (busy_ff) begin
            if (cnt_ff >= CONV_LIMIT) begin
               busy_ff <= 1'b0;
               done_ff <= 1'b1;
               cnt_ff  <= '0;
            end else begin
               cnt_ff <= cnt_ff + 8'h01;
            end
         end
      end
   end

   assign busy_o = busy_ff;
   assign done_o = done_ff;

endmodule // sac_conv_timer

// >>> verification/sac_top_assertions.sv
// checker on the ports of the converter serial control block
`timescale 1ns/1ps
module sac_top_checker (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic sclk_i,
   input wire logic cs_n_i,
   input wire logic serial_result_out_oe_o,
   input wire logic powerdown_reset_n_i,
   input wire logic sample_switch_o,
   input wire logic busy_o,
   input wire logic nap_o,
   input wire logic powerdown_o,
   input wire logic result_invalid_o
);
   logic       run;         // both resets released
   logic [4:0] low_cnt_ff;  // clk cycles with the pin held low, saturating
   assign run = reset_n_i & powerdown_reset_n_i;
   // count how long the pin has been low
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) low_cnt_ff <= 5'h00;
      else if (powerdown_reset_n_i) low_cnt_ff <= 5'h00;
      else if (low_cnt_ff != 5'h1f) low_cnt_ff <= low_cnt_ff + 5'h01;
   end
   // aborted conversions (chip select still low) are left out
   a_busy_length:
      assert property (@(posedge clk_i) disable iff (!run) $rose(busy_o) && cs_n_i |-> busy_o[*3] ##1 !busy_o)
      else $error("busy width wrong");
   a_nap_entry:
      assert property (@(posedge clk_i) disable iff (!run) $fell(busy_o) && cs_n_i |-> ##[0:1] nap_o)
      else $error("no nap after busy");
   a_abort_reset:
      assert property (@(posedge clk_i) disable iff (!reset_n_i) !powerdown_reset_n_i |-> !busy_o)
      else $error("busy in reset");
   a_output_off:
      assert property (@(posedge clk_i) disable iff (!reset_n_i) !powerdown_reset_n_i |-> !serial_result_out_oe_o)
      else $error("data driven in reset");
   a_powerdown_entry:
      assert property (@(posedge clk_i) disable iff (!reset_n_i) low_cnt_ff == 5'h0f |-> powerdown_o)
      else $error("no powerdown");
   a_wake_bound:
      assert property (@(posedge clk_i) disable iff (!reset_n_i) $rose(powerdown_reset_n_i) |-> ##[0:26] !powerdown_o)
      else $error("wake too slow");
   a_convert_start:
      assert property (@(posedge clk_i) disable iff (!run) $fell(sample_switch_o) && !powerdown_o |-> ##[0:6] busy_o)
      else $error("no conversion after sample");
   a_invalid_set:
      assert property (@(posedge clk_i) disable iff (!reset_n_i)
         $fell(powerdown_reset_n_i) |-> ##[1:4] result_invalid_o)
      else $error("result not marked invalid");
   a_oe_select:
      assert property (@(posedge sclk_i) disable iff (!reset_n_i) serial_result_out_oe_o |-> !cs_n_i)
      else $error("data driven while deselected");
endmodule // sac_top_checker
bind sac_top sac_top_checker i_sac_top_checker (.clk_i(clk_i), .reset_n_i(reset_n_i), .sclk_i(sclk_i),
   .cs_n_i(cs_n_i), .serial_result_out_oe_o(serial_result_out_oe_o), .powerdown_reset_n_i(powerdown_reset_n_i),
   .sample_switch_o(sample_switch_o), .busy_o(busy_o), .nap_o(nap_o), .powerdown_o(powerdown_o),
   .result_invalid_o(result_invalid_o));

// >>> verification/sac_host_model.sv
// host model: makes the serial clock, chip select and strobe, shifts the word in
`timescale 1ns/1ps
module sac_host_model (
   // device side
   input  wire logic sdo_i,
   input  wire logic sdo_oe_i,
   // host-driven link pins
   output logic      sclk_o,
   output logic      cs_n_o,
   output logic      fs_o
);
   logic [13:0] word;     // last word shifted in, msb first
   logic        oe_seen;  // output enable after the first edge
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      fs_o = 1'b1;
   end
   // one frame of n edges at 80 ns; clock stands still outside it
   task automatic frame(input logic fsm, input int n, input logic keep);
      int k;
      cs_n_o = 1'b0;
      fs_o = !fsm;
      #40;
      // strobe edge needs a low sample first, chip select already low
      if (fsm) begin
         sclk_o = 1'b1;
         #40;
         sclk_o = 1'b0;
         fs_o = 1'b1;
         #40;
      end
      for (k = 1; k <= n; k++) begin
         sclk_o = 1'b1;
         #40;
         sclk_o = 1'b0;
         if (k == 1) oe_seen = sdo_oe_i;
         if (k <= 14) word[14-k] = sdo_i;
         if (fsm) fs_o = 1'b0;
         #40;
      end
      if (!keep) cs_n_o = 1'b1;
   endtask
endmodule // sac_host_model

// >>> verification/tb.sv
// self-checking bench for the converter serial control block
`timescale 1ns/1ps
module tb;
   import sac_pkg::*;
   logic        clk = 1'b0;
   logic        reset_n, pd_n, mode_fs;
   logic [13:0] sar_code;
   wire         sclk, cs_n, fs, serial_result_out, sdo_oe, sample_sw, busy, nap, pdown, invalid;
   int          failures = 0;
   int          n_tests = 0;
   always #50 clk = ~clk;
   sac_top i_sac_top (.clk_i(clk), .reset_n_i(reset_n), .sclk_i(sclk), .cs_n_i(cs_n), .frame_sync_strobe_i(fs),
      .serial_result_out_o(serial_result_out), .serial_result_out_oe_o(sdo_oe), .mode_frame_sync_i(mode_fs),
      .powerdown_reset_n_i(pd_n), .sar_code_i(sar_code), .sample_switch_o(sample_sw), .busy_o(busy),
      .nap_o(nap), .powerdown_o(pdown), .result_invalid_o(invalid));
   sac_host_model i_sac_host_model (.sdo_i(serial_result_out), .sdo_oe_i(sdo_oe), .sclk_o(sclk), .cs_n_o(cs_n), .fs_o(fs));
   // ************************************************
   // helpers
   // ************************************************
   task automatic wrap_up;
      $display("checks %0d, mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk_word(input logic [13:0] got, input logic [13:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: word %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: flag %b, expected %b", $time, got, exp);
      end
   endtask
   // bounded wait; a hang ends the run
   task automatic wait_busy(input logic lvl);
      int i;
      for (i = 0; i < 40 && busy !== lvl; i++) @(negedge clk);
      if (busy !== lvl) begin
         failures++;
         $display("wrong value at %0t: busy wait ran out", $time);
         wrap_up;
      end
   endtask
   // one full frame and the conversion it starts
   task automatic conv_frame(input logic fsm);
      @(negedge clk);
      i_sac_host_model.frame(fsm, 16, 1'b0);
      chk_bit(i_sac_host_model.oe_seen, 1'b1);
      chk_bit(nap, 1'b0);
      wait_busy(1'b1);
      wait_busy(1'b0);
      @(negedge clk);
      chk_bit(nap, 1'b1);
   endtask
   // ************************************************
   // scenarios
   // ************************************************
   task automatic t_codes;
      logic [13:0] codes [4];
      int          i;
      codes = '{CODE_FULL_SCALE, CODE_MIDSCALE, 14'h1fff, CODE_ZERO};
      for (i = 0; i < 4; i++) conv_frame(1'b0);
      chk_bit(invalid, 1'b1);
      for (i = 0; i < 5; i++) begin
         if (i < 4) sar_code = codes[i];
         conv_frame(1'b0);
         if (i == 0) chk_bit(invalid, 1'b0);
         if (i > 0) chk_word(i_sac_host_model.word, codes[i-1]);
      end
      $display("done: codes");
   endtask
   task automatic t_fs;
      mode_fs = 1'b1;
      sar_code = CODE_MIDSCALE;
      conv_frame(1'b1);
      chk_word(i_sac_host_model.word, CODE_ZERO);
      conv_frame(1'b1);
      chk_word(i_sac_host_model.word, CODE_MIDSCALE);
      $display("done: strobe mode");
   endtask
   // clock on past edge 16 with chip select low, then restart just after busy falls, while the link still sees busy
   task automatic t_abort;
      sar_code = 14'h0155;
      i_sac_host_model.frame(1'b1, 22, 1'b1);
      i_sac_host_model.frame(1'b1, 16, 1'b0);
      chk_word(i_sac_host_model.word, CODE_ABORT);
      wait_busy(1'b1);
      wait_busy(1'b0);
      $display("done: abort");
   endtask
   task automatic t_pin;
      int i;
      mode_fs = 1'b0;
      i_sac_host_model.frame(1'b0, 16, 1'b1);
      wait_busy(1'b1);
      pd_n = 1'b0;
      #45;
      chk_bit(busy, 1'b0);
      chk_bit(sdo_oe, 1'b0);
      i_sac_host_model.frame(1'b0, 0, 1'b0);
      repeat (3) @(negedge clk);
      chk_bit(pdown, 1'b0);
      pd_n = 1'b1;
      repeat (3) @(negedge clk);
      conv_frame(1'b0);
      chk_bit(invalid, 1'b1);
      pd_n = 1'b0;
      repeat (16) @(negedge clk);
      chk_bit(pdown, 1'b1);
      pd_n = 1'b1;
      for (i = 0; i < 26 && pdown !== 1'b0; i++) @(negedge clk);
      chk_bit(pdown, 1'b0);
      conv_frame(1'b0);
      $display("done: pin reset");
   endtask
   initial begin
      reset_n = 1'b0;
      pd_n = 1'b1;
      mode_fs = 1'b0;
      sar_code = CODE_ZERO;
      repeat (16) @(posedge clk);
      @(negedge clk);
      reset_n = 1'b1;
      repeat (3) @(negedge clk);
      t_codes;
      t_fs;
      t_abort;
      t_pin;
      wrap_up;
   end
endmodule // tb
